// *** include/ofdm_plc_tx_defines.svh ***
// Constants of the OFDM powerline transmit bit chain.
// Assumes a single 100 MHz clock and one frame in flight at a time.
//
// Summary of operation
// - Rate half coder, K seven, 1111001/1011011
// - Coder register cleared at frame start
// - Eight zero flush bits after header
// - Six zero flush bits after coded payload
// - Scramble header and payload in every frame
// - XOR each bit with 127-bit sequence
// - Seven stage generator seeded all ones
// - Generator reloaded at each frame start
// - Interleave coded bits only, else bypass
// - Block interleave with stride s permutation
// - Block is 96 or 84 times bits/carrier
// - Stride 8(1+floor(c/2)) payload, 7 header
// - Receive de-interleaver inverts the permutation
// - Payload: one pilot, 96 data carriers
// - Header: 13 pilots, 84 binary data carriers
// - Groups of bits, first bit most significant
// - Differential keying with 2, 4, 8 increments
// - Carriers in bins 86-182, mirror conjugated
// - 48 sample cyclic prefix, 560 samples
// - Prefix windowing optional, left outside
// - Header binary and coded; payload per scheme
// - Field bits enter most significant first
// - Payload pad bits are all zero
`ifndef OFDM_PLC_TX_DEFINES_SVH
`define OFDM_PLC_TX_DEFINES_SVH

// ****************************************
// Coder and scrambler
// ****************************************
`define ENC_G0 7'h79
`define ENC_G1 7'h5b
`define HDR_FLUSH 4'h8
`define PAY_FLUSH 4'h6
`define SCR_SEED 7'h7f
`define SCR_TAP_A 6
`define SCR_TAP_B 3

// ****************************************
// Blocks, strides and steps
// ****************************************
`define BPC_1 2'h1
`define BPC_2 2'h2
`define BPC_3 2'h3
`define BLK_HDR 9'h054
`define BLK_P1 9'h060
`define BLK_P2 9'h0c0
`define BLK_P3 9'h120
`define STRIDE_HDR 5'h07
`define STRIDE_P1 5'h08
`define STRIDE_P23 5'h10
`define STEP_P12 9'h00c
`define STEP_P3 9'h012
`define BUF_BITS 288

// ****************************************
// Bin map and prefix
// ****************************************
`define NUM_CARRIERS 97
`define PILOT_MASK 3'h0
`define BIN_FIRST 9'h056
`define BIN_LAST 9'h0b6
`define MIR_FIRST 9'h14a
`define MIR_LAST 9'h1aa
`define FFT_LAST 9'h1ff
`define FFT_N 10'h200
`define CP_LEN 10'h030
`define SYM_LAST 10'h22f

`endif

// *** include/ofdm_plc_tx_pkg.sv ***
// Types of the OFDM powerline transmit bit chain.
// Assumes the constants header is on the include path.
`include "ofdm_plc_tx_defines.svh"

package ofdm_plc_tx_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_FILL = 2'h1,
        ST_MAP = 2'h3,
        ST_CPFX = 2'h2
    } st_t;

    typedef struct packed {
        logic coded;
        logic [1:0] bpc;
    } mode_t;

    typedef struct packed {
        logic valid;
        logic [8:0] index;
        logic active;
        logic [2:0] phase;
    } bin_t;

    typedef struct packed {
        logic valid;
        logic [9:0] n;
        logic [8:0] addr;
        logic prefix;
    } samp_t;

    typedef struct packed {
        logic valid;
        logic header;
        logic [1:0] bpc;
        logic [8:0] index;
    } deint_req_t;

    typedef struct packed {
        logic valid;
        logic [8:0] index;
    } deint_rsp_t;

endpackage : ofdm_plc_tx_pkg

// *** verilog/ofdm_plc_tx_bit_chain.sv ***
// Transmit bit chain: coder, scrambler, interleaver, differential
// mapper onto IFFT bins and cyclic prefix read addressing.
// Assumes the MAC holds bit_valid/bit_data steady until taken and
// an external IFFT with its own sample memory.
`timescale 1ns/10ps
`include "ofdm_plc_tx_defines.svh"

module ofdm_plc_tx_bit_chain (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Frame control
    input wire logic frame_start,
    input wire ofdm_plc_tx_pkg::mode_t mode_in,
    output logic busy,
    output logic frame_done,
    // Bit stream from the MAC
    input wire logic bit_valid,
    input wire logic bit_data,
    input wire logic bit_last,
    output logic bit_ready,
    // Bin stream to the IFFT
    output ofdm_plc_tx_pkg::bin_t bin_out,
    // Sample read addressing with prefix
    output ofdm_plc_tx_pkg::samp_t samp_out,
    // Receive de-interleaver index translation
    input wire ofdm_plc_tx_pkg::deint_req_t deint_req,
    output ofdm_plc_tx_pkg::deint_rsp_t deint_rsp
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        ofdm_plc_tx_pkg::st_t st;
        logic hdr;
        ofdm_plc_tx_pkg::mode_t pay;
        logic [5:0] sr;
        logic [6:0] scr;
        logic half;
        logic cur_in;
        logic last_seen;
        logic [3:0] flush;
        logic pend;
        logic [8:0] k;
        logic [4:0] kmod;
        logic [4:0] kdiv;
        logic [8:0] base;
        logic [`BUF_BITS-1:0] buffer;
        logic [`NUM_CARRIERS-1:0][2:0] ph;
        logic [2:0] acc;
        logic [8:0] rd;
        logic [8:0] cnt;
        logic [9:0] n;
        ofdm_plc_tx_pkg::bin_t bin;
        ofdm_plc_tx_pkg::samp_t samp;
        logic done;
        ofdm_plc_tx_pkg::deint_rsp_t dr;
    } state_t;

    state_t cur_q;
    state_t nxt_d;

    // ****************************************
    // Block geometry
    // ****************************************
    // block size from bits per carrier
    function automatic logic [8:0] blk_size(input logic hdr,
                                            input logic [1:0] bpc);
        logic [8:0] r;
        r = `BLK_P1;
        if (hdr) begin
            r = `BLK_HDR;
        end else if (bpc == `BPC_2) begin
            r = `BLK_P2;
        end else if (bpc == `BPC_3) begin
            r = `BLK_P3;
        end
        return r;
    endfunction : blk_size

    function automatic logic [4:0] stride(input logic hdr,
                                          input logic [1:0] bpc);
        logic [4:0] r;
        r = `STRIDE_P1;
        if (hdr) begin
            r = `STRIDE_HDR;
        end else if (bpc == `BPC_2 || bpc == `BPC_3) begin
            r = `STRIDE_P23;
        end
        return r;
    endfunction : stride

    // Row step, block size over stride
    function automatic logic [8:0] step(input logic hdr,
                                        input logic [1:0] bpc);
        return (!hdr && bpc == `BPC_3) ? `STEP_P3 : `STEP_P12;
    endfunction : step

    function automatic logic [8:0] deint_index(input logic [8:0] i,
                                               input logic [8:0] nb,
                                               input logic [4:0] s);
        logic [13:0] si;
        logic [13:0] q;
        logic [13:0] sub;
        si = 14'(s) * 14'(i);
        q = si / 14'(nb);
        sub = 14'(14'(nb - 9'h001) * q);
        return 9'(si - sub);
    endfunction : deint_index

    function automatic logic bit_at(input logic [`BUF_BITS-1:0] v,
                                    input logic [8:0] idx);
        return (idx < 9'(`BUF_BITS)) ? v[idx] : 1'b0;
    endfunction : bit_at

    // ****************************************
    // Next state
    // ****************************************
    logic coded_now;
    logic [1:0] map_bpc;
    logic have;
    logic take;
    logic enc_in;
    logic wbit;
    logic fb;
    logic [8:0] pos;
    logic [8:0] bsz;
    logic [6:0] p;
    logic pilot;
    logic [2:0] grp;
    logic [2:0] ph;

    assign coded_now = cur_q.hdr | cur_q.pay.coded;
    assign map_bpc = cur_q.hdr ? `BPC_1 : cur_q.pay.bpc;
    assign bsz = blk_size(cur_q.hdr, cur_q.pay.bpc);

    always_comb begin
        nxt_d = cur_q;
        nxt_d.bin.valid = 1'b0;
        nxt_d.samp.valid = 1'b0;
        nxt_d.done = 1'b0;
        have = 1'b0;
        take = 1'b0;
        enc_in = 1'b0;
        wbit = 1'b0;
        fb = 1'b0;
        pos = 9'h000;
        p = 7'h00;
        pilot = 1'b0;
        grp = 3'h0;
        ph = 3'h0;
        nxt_d.dr.valid = deint_req.valid;
        if (deint_req.valid) begin
            nxt_d.dr.index = deint_index(deint_req.index,
                blk_size(deint_req.header, deint_req.bpc),
                stride(deint_req.header, deint_req.bpc));
        end
        case (cur_q.st)
            ofdm_plc_tx_pkg::ST_IDLE: begin
                if (frame_start) begin
                    nxt_d.st = ofdm_plc_tx_pkg::ST_FILL;
                    nxt_d.hdr = 1'b1;
                    nxt_d.pay = mode_in;
                    nxt_d.sr = '0;
                    nxt_d.scr = `SCR_SEED;
                    nxt_d.half = 1'b0;
                    nxt_d.last_seen = 1'b0;
                    nxt_d.flush = 4'h0;
                    nxt_d.pend = 1'b0;
                    nxt_d.k = 9'h000;
                    nxt_d.kmod = 5'h00;
                    nxt_d.kdiv = 5'h00;
                    nxt_d.base = 9'h000;
                end
            end
            ofdm_plc_tx_pkg::ST_FILL: begin
                have = 1'b1;
                if (!coded_now || !cur_q.half) begin
                    if (!cur_q.last_seen) begin
                        have = bit_valid;
                        take = bit_valid;
                        enc_in = bit_data;
                    end else if (cur_q.flush != 4'h0) begin
                        nxt_d.flush = cur_q.flush - 4'h1;
                    end
                end else begin
                    enc_in = cur_q.cur_in;
                end
                if (take && bit_last) begin
                    nxt_d.last_seen = 1'b1;
                    nxt_d.flush = cur_q.hdr ? `HDR_FLUSH :
                        (cur_q.pay.coded ? `PAY_FLUSH : 4'h0);
                end
                if (have) begin
                    if (coded_now) begin
                        if (!cur_q.half) begin
                            wbit = ^({enc_in, cur_q.sr} & `ENC_G0);
                            nxt_d.cur_in = enc_in;
                            nxt_d.half = 1'b1;
                        end else begin
                            wbit = ^({enc_in, cur_q.sr} & `ENC_G1);
                            nxt_d.sr = {enc_in, cur_q.sr[5:1]};
                            nxt_d.half = 1'b0;
                        end
                    end else begin
                        wbit = enc_in;
                    end
                    // feedback from stages seven and four
                    fb = cur_q.scr[`SCR_TAP_A] ^ cur_q.scr[`SCR_TAP_B];
                    // one sequence bit per bit written to the buffer
                    wbit = wbit ^ fb;
                    nxt_d.scr = {cur_q.scr[5:0], fb};
                    pos = coded_now ? 9'(cur_q.base + 9'(cur_q.kdiv))
                                    : cur_q.k;
                    nxt_d.buffer[pos] = wbit;
                    nxt_d.k = cur_q.k + 9'h001;
                    if (cur_q.kmod == stride(cur_q.hdr, cur_q.pay.bpc)
                                      - 5'h01) begin
                        nxt_d.kmod = 5'h00;
                        nxt_d.kdiv = cur_q.kdiv + 5'h01;
                        nxt_d.base = 9'h000;
                    end else begin
                        nxt_d.kmod = cur_q.kmod + 5'h01;
                        nxt_d.base = cur_q.base +
                            step(cur_q.hdr, cur_q.pay.bpc);
                    end
                    if (cur_q.k == bsz - 9'h001) begin
                        nxt_d.st = ofdm_plc_tx_pkg::ST_MAP;
                        nxt_d.k = 9'h000;
                        nxt_d.kmod = 5'h00;
                        nxt_d.kdiv = 5'h00;
                        nxt_d.base = 9'h000;
                        nxt_d.pend = nxt_d.last_seen &&
                                     (nxt_d.flush == 4'h0);
                        nxt_d.cnt = 9'h000;
                        nxt_d.rd = 9'h000;
                        nxt_d.acc = 3'h0;
                    end
                end
            end
            ofdm_plc_tx_pkg::ST_MAP: begin
                nxt_d.bin.valid = 1'b1;
                nxt_d.bin.index = cur_q.cnt;
                nxt_d.bin.active = 1'b0;
                nxt_d.bin.phase = 3'h0;
                if (cur_q.cnt >= `BIN_FIRST && cur_q.cnt <= `BIN_LAST) begin
                    p = 7'(cur_q.cnt - `BIN_FIRST);
                    pilot = cur_q.hdr ? (p[2:0] == `PILOT_MASK)
                                      : (p == 7'h00);
                    grp = {bit_at(cur_q.buffer, cur_q.rd),
                           bit_at(cur_q.buffer, cur_q.rd + 9'h001),
                           bit_at(cur_q.buffer, cur_q.rd + 9'h002)};
                    grp = grp & ~(3'h7 >> map_bpc);
                    ph = pilot ? 3'h0 : 3'(cur_q.acc + grp);
                    if (!pilot) begin
                        nxt_d.rd = cur_q.rd + 9'(map_bpc);
                    end
                    nxt_d.acc = ph;
                    nxt_d.ph[p] = ph;
                    nxt_d.bin.active = 1'b1;
                    nxt_d.bin.phase = ph;
                end else if (cur_q.cnt >= `MIR_FIRST &&
                             cur_q.cnt <= `MIR_LAST) begin
                    p = 7'(`MIR_LAST - cur_q.cnt);
                    nxt_d.bin.active = 1'b1;
                    nxt_d.bin.phase = 3'h0 - cur_q.ph[p];
                end
                nxt_d.cnt = cur_q.cnt + 9'h001;
                if (cur_q.cnt == `FFT_LAST) begin
                    nxt_d.st = ofdm_plc_tx_pkg::ST_CPFX;
                    nxt_d.n = 10'h000;
                end
            end
            ofdm_plc_tx_pkg::ST_CPFX: begin
                nxt_d.samp.valid = 1'b1;
                nxt_d.samp.n = cur_q.n;
                nxt_d.samp.prefix = cur_q.n < `CP_LEN;
                nxt_d.samp.addr = (cur_q.n < `CP_LEN)
                    ? 9'(cur_q.n + `FFT_N - `CP_LEN)
                    : 9'(cur_q.n - `CP_LEN);
                nxt_d.n = cur_q.n + 10'h001;
                if (cur_q.n == `SYM_LAST) begin
                    nxt_d.st = ofdm_plc_tx_pkg::ST_FILL;
                    if (cur_q.pend) begin
                        nxt_d.pend = 1'b0;
                        if (cur_q.hdr) begin
                            nxt_d.hdr = 1'b0;
                            nxt_d.last_seen = 1'b0;
                        end else begin
                            nxt_d.st = ofdm_plc_tx_pkg::ST_IDLE;
                            nxt_d.done = 1'b1;
                        end
                    end
                end
            end
            default: begin
                nxt_d.st = ofdm_plc_tx_pkg::ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cur_q <= '0;
        end else begin
            cur_q <= nxt_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign bit_ready = (cur_q.st == ofdm_plc_tx_pkg::ST_FILL) &&
                       !cur_q.last_seen && !(coded_now && cur_q.half);
    assign busy = cur_q.st != ofdm_plc_tx_pkg::ST_IDLE;
    assign frame_done = cur_q.done;
    assign bin_out = cur_q.bin;
    assign samp_out = cur_q.samp;
    assign deint_rsp = cur_q.dr;

endmodule : ofdm_plc_tx_bit_chain

// *** bench/ofdm_plc_tx_bit_chain_assertions.sv ***
// Port checker for the transmit bit chain: bins, prefix, de-interleave.
// Assumes it is bound onto the top module; one clock domain.
`timescale 1ns/10ps

module ofdm_plc_tx_bit_chain_assertions (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Bin and sample streams
    input wire ofdm_plc_tx_pkg::bin_t bin_out,
    input wire ofdm_plc_tx_pkg::samp_t samp_out,
    // De-interleaver
    input wire ofdm_plc_tx_pkg::deint_req_t deint_req,
    input wire ofdm_plc_tx_pkg::deint_rsp_t deint_rsp
);
    logic [8:0] blk_n;
    logic [4:0] stride;
    logic [12:0] prod;
    logic [8:0] exp_d;
    logic [8:0] exp_q;
    logic [2:0] mem [0:96];

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    // ****************************************
    // Helper logic
    // ****************************************
    always_comb begin
        blk_n = deint_req.header ? 9'h054 : deint_req.bpc == 2'h3 ? 9'h120 :
            deint_req.bpc == 2'h2 ? 9'h0c0 : 9'h060;
        stride = deint_req.header ? 5'h07 : deint_req.bpc[1] ? 5'h10 : 5'h08;
        prod = 13'(stride) * 13'(deint_req.index);
        exp_d = 9'(prod - 13'(blk_n - 9'h001) * (prod / 13'(blk_n)));
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            exp_q <= 9'h000;
        end else begin
            exp_q <= exp_d;
        end
    end

    always_ff @(posedge clk) begin
        if (bin_out.valid && bin_out.index inside {[9'h056:9'h0b6]}) begin
            mem[bin_out.index - 9'h056] <= bin_out.phase;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    a_deint_index: assert property (
        deint_req.valid |=> deint_rsp.valid && deint_rsp.index == exp_q)
        else $error("de-interleave index wrong");
    a_deint_idle: assert property (
        !deint_req.valid |=> !deint_rsp.valid)
        else $error("de-interleave answer without request");
    a_bin_active: assert property (
        bin_out.valid |-> bin_out.active == (bin_out.index inside
        {[9'h056:9'h0b6], [9'h14a:9'h1aa]}))
        else $error("bin active flag wrong");
    a_bin_quiet: assert property (
        bin_out.valid && !bin_out.active |-> bin_out.phase == 3'h0)
        else $error("unused bin not zero");
    a_bin_order: assert property (
        bin_out.valid && bin_out.index != 9'h1ff |=>
        bin_out.valid && bin_out.index == $past(bin_out.index) + 9'h001)
        else $error("bin sequence broken");
    a_mirror_conj: assert property (
        bin_out.valid && bin_out.index inside {[9'h14a:9'h1aa]} |->
        bin_out.phase == 3'(3'h0 - mem[9'(9'h1aa - bin_out.index)]))
        else $error("mirror bin not conjugate");
    a_prefix_start: assert property (
        bin_out.valid && bin_out.index == 9'h1ff |=>
        samp_out.valid && samp_out.n == 10'h000 && samp_out.prefix)
        else $error("samples do not follow bins");
    a_samp_addr: assert property (
        samp_out.valid |-> samp_out.prefix == (samp_out.n < 10'h030) &&
        samp_out.addr == 9'(samp_out.n < 10'h030 ?
        samp_out.n + 10'h1d0 : samp_out.n - 10'h030))
        else $error("sample address or prefix wrong");
    a_samp_order: assert property (
        samp_out.valid && samp_out.n != 10'h22f |=>
        samp_out.valid && samp_out.n == $past(samp_out.n) + 10'h001)
        else $error("sample sequence broken");
endmodule : ofdm_plc_tx_bit_chain_assertions

bind ofdm_plc_tx_bit_chain ofdm_plc_tx_bit_chain_assertions chk (
    .clk(clk), .reset_n(reset_n), .bin_out(bin_out), .samp_out(samp_out),
    .deint_req(deint_req), .deint_rsp(deint_rsp));

// *** bench/mac_bit_source.sv ***
// MAC side model feeding field bits to the transmit chain.
// Assumes the bench queues bits through push and sets gap.
`timescale 1ns/10ps

module mac_bit_source (
    // Clock
    input wire logic clk,
    // Bit stream
    input wire logic bit_ready,
    output logic bit_valid,
    output logic bit_data,
    output logic bit_last
);
    logic qd[$];
    logic ql[$];
    int gap = 0;
    int idle = 0;

    task automatic push(input logic d, input logic l);
        qd.push_back(d);
        ql.push_back(l);
    endtask : push

    task automatic drop();
        qd.delete();
        ql.delete();
    endtask : drop

    initial begin
        bit_valid = 1'b0;
        bit_data = 1'b0;
        bit_last = 1'b0;
        forever begin
            @(posedge clk);
            if (bit_valid && bit_ready && qd.size() > 0) begin
                void'(qd.pop_front());
                void'(ql.pop_front());
                idle = gap;
            end
            #1;
            if (idle > 0 || qd.size() == 0) begin
                idle = idle > 0 ? idle - 1 : 0;
                bit_valid = 1'b0;
                bit_data = ~bit_data;
                bit_last = 1'b0;
            end else begin
                bit_valid = 1'b1;
                bit_data = qd[0];
                bit_last = ql[0];
            end
        end
    end
endmodule : mac_bit_source

// *** bench/ofdm_plc_tx_bit_chain_test.sv ***
// Self-checking bench for the transmit bit chain.
// Assumes the package, the design and the MAC model are compiled first.
`timescale 1ns/10ps

module ofdm_plc_tx_bit_chain_test;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic frame_start = 1'b0;
    ofdm_plc_tx_pkg::mode_t mode_in = '0;
    logic busy, frame_done, bit_valid, bit_data, bit_last, bit_ready;
    ofdm_plc_tx_pkg::bin_t bin_out;
    ofdm_plc_tx_pkg::samp_t samp_out;
    ofdm_plc_tx_pkg::deint_req_t deint_req = '0;
    ofdm_plc_tx_pkg::deint_rsp_t deint_rsp;
    int err_total = 0;
    int cmp_count = 0;
    logic strm[$];
    logic [5:0] enc_sr;
    logic [6:0] scr;
    logic [2:0] ph [0:96];

    always #5 clk = ~clk;

    ofdm_plc_tx_bit_chain dut (.clk(clk), .reset_n(reset_n),
        .frame_start(frame_start), .mode_in(mode_in), .busy(busy),
        .frame_done(frame_done), .bit_valid(bit_valid), .bit_data(bit_data),
        .bit_last(bit_last), .bit_ready(bit_ready), .bin_out(bin_out),
        .samp_out(samp_out), .deint_req(deint_req), .deint_rsp(deint_rsp));
    mac_bit_source mac (.clk(clk), .bit_ready(bit_ready),
        .bit_valid(bit_valid), .bit_data(bit_data), .bit_last(bit_last));

    // ****************************************
    // Common tasks and reference model
    // ****************************************
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_of_test();
        $display("Compares %0d, errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic cyc(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask : cyc

    task automatic emit(input logic b);
        logic o;
        o = scr[6] ^ scr[3];
        scr = {scr[5:0], o};
        strm.push_back(b ^ o);
    endtask : emit

    task automatic feed(input logic b, input logic coded);
        logic [6:0] v;
        v = {b, enc_sr};
        if (coded) begin
            emit(^(v & 7'h79));
            emit(^(v & 7'h5b));
            enc_sr = v[6:1];
        end else begin
            emit(b);
        end
    endtask : feed

    task automatic field(input int n, input int key, input int tot,
                         input logic coded);
        logic b;
        for (int i = 0; i < tot; i++) begin
            b = i < n ? 1'(((i * key) >> 2) ^ i) : 1'b0;
            if (i < n) mac.push(b, i == n - 1);
            feed(b, coded);
        end
    endtask : field

    task automatic symbol(input int nb, input int s, input int bpc,
                          input logic hdr, input logic coded, input logic last);
        logic v [0:287];
        logic w [0:287];
        logic [2:0] inc;
        int k, c, t;
        for (k = 0; k < nb; k++) v[k] = strm.pop_front();
        for (k = 0; k < nb; k++) begin
            if (coded) w[(nb / s) * (k % s) + k / s] = v[k];
            else w[k] = v[k];
        end
        t = 0;
        for (c = 0; c < 97; c++) begin
            if (hdr ? c % 8 == 0 : c == 0) begin
                ph[c] = 3'h0;
            end else begin
                inc = 3'h0;
                repeat (bpc) begin
                    inc = {inc[1:0], w[t]};
                    t++;
                end
                ph[c] = ph[c - 1] + 3'(inc * (8 >> bpc));
            end
        end
        k = 0;
        while (bin_out.valid !== 1'b1 && k < 4000) begin
            cyc(1);
            k++;
        end
        for (k = 0; k < 512; k++) begin
            c = k >= 86 && k <= 182 ? k - 86 : k >= 330 && k <= 426 ? 426 - k : 0;
            chk({bin_out.valid, bin_out.index, bin_out.active, bin_out.phase},
                {1'b1, 9'(k), c > 0 || k == 86 || k == 426,
                !(c > 0 || k == 86 || k == 426) ? 3'h0 :
                k < 256 ? ph[c] : 3'h0 - ph[c]});
            cyc(1);
        end
        for (k = 0; k < 560; k++) begin
            chk({frame_done, samp_out.valid, samp_out.n,
                 samp_out.addr, samp_out.prefix}, {last && k == 559, 1'b1,
                 10'(k), 9'(k < 48 ? k + 464 : k - 48), k < 48});
            cyc(1);
        end
        chk({frame_done, busy}, {1'b0, !last});
    endtask : symbol

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic deint();
        int n, s, m;
        for (m = 0; m < 4; m++) begin
            n = m == 0 ? 84 : 96 * m;
            s = m == 0 ? 7 : m == 1 ? 8 : 16;
            for (int i = 0; i < n; i++) begin
                deint_req = {1'b1, m == 0, 2'(m), 9'(i)};
                cyc(1);
                chk(deint_rsp, {1'b1, 9'(s * i - (n - 1) * (s * i / n))});
            end
        end
        deint_req = '0;
        cyc(1);
    endtask : deint

    task automatic frame(input logic coded, input logic [1:0] bpc,
                         input int msdu, input int gap, input int cut);
        int nb, syms;
        nb = 96 * bpc;
        enc_sr = 6'h00;
        scr = 7'h7f;
        mac.gap = gap;
        field(76, 5, 84, 1'b1);
        syms = ((msdu + (coded ? 6 : 0)) * (coded ? 2 : 1) + nb - 1) / nb;
        field(msdu, 3, syms * nb / (coded ? 2 : 1), coded);
        mode_in = {coded, bpc};
        cyc(2);
        frame_start = 1'b1;
        cyc(1);
        frame_start = 1'b0;
        chk({busy, bit_ready}, 2'h3);
        if (cut > 0) begin
            cyc(cut);
            reset_n = 1'b0;
            mac.drop();
            strm.delete();
            cyc(1);
            chk({busy, bit_ready, bin_out.valid, samp_out.valid}, 4'h0);
            reset_n = 1'b1;
        end else begin
            symbol(84, 7, 1, 1'b1, 1'b1, 1'b0);
            symbol(84, 7, 1, 1'b1, 1'b1, 1'b0);
            for (int i = 0; i < syms; i++) begin
                symbol(nb, bpc == 2'h1 ? 8 : 16, bpc, 1'b0, coded,
                       i == syms - 1);
            end
        end
    endtask : frame

    initial begin
        repeat (2) @(posedge clk);
        #1;
        chk({busy, bit_ready, frame_done, bin_out.valid, samp_out.valid,
             deint_rsp.valid}, 6'h00);
        reset_n = 1'b1;
        deint();
        frame(1'b1, 2'h2, 80, 0, 0);
        frame(1'b0, 2'h3, 280, 3, 0);
        frame(1'b1, 2'h3, 100, 2, 0);
        frame(1'b1, 2'h3, 120, 0, 90);
        frame(1'b1, 2'h1, 90, 1, 0);
        end_of_test();
    end

    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        end_of_test();
    end
endmodule : ofdm_plc_tx_bit_chain_test
